// ==== hdl/sci_map.svh ====
// Register offsets, field positions, reset values and sampling points of the receive status block.
// Behaviour
// - Start bit noisy if fewer than three highs precede the edge, or samples 3/5/7 high.
// - Start bit noisy if sample 8, 9 or 10 reads high.
// - Data bit noisy when samples 8, 9 and 10 disagree.
// - Data bit value is the majority of samples 8, 9 and 10.
// - Wait mode changes nothing; enabled serial interrupts wake the device.
// - Halt freezes all registers, stops transfers, and never wakes the device.
// - One shared interrupt; each event needs its enable and a clear global mask.
// - Tx empty (bit 7) sets on holding-to-shifter move; clears on status then write.
// - Tx complete (bit 6) sets after a data frame; clears on status then write.
// - Rx full (bit 5) sets on word transfer; clears on status then data read.
// - Idle (bit 4) sets on idle line; rearmed only after rx full sets.
// - Overrun (bit 3) keeps held word, drops shifter word, interrupts via rx enable.
// - Noise (bit 2) sets on noisy frame; no own interrupt; status then read clears.
// - Framing error (bit 1) on bad stop bit; no own interrupt; status then read clears.
// - Framing error plus overrun on one word sets only overrun.
// - Parity error (bit 0) on mismatch; interrupts if enabled; status then data access clears.
// - Status resets to tx empty and tx complete set; all status bits read-only.
// - Every received bit is sampled sixteen times, positions numbered within the bit.
// - Rx interrupt enable requests service while overrun or rx full is set.
`ifndef SCI_MAP_SVH
`define SCI_MAP_SVH
`define SCI_OFS_STATUS   3'h0
`define SCI_OFS_DATA     3'h1
`define SCI_OFS_CTRL1    3'h2
`define SCI_OFS_CTRL2    3'h3
`define SCI_OFS_BAUD     3'h4
`define SCI_STATUS_RST   8'hC0
`define SCI_CTRL1_M      4
`define SCI_CTRL1_PCE    2
`define SCI_CTRL1_PS     1
`define SCI_IEN_PARITY   0
`define SCI_IEN_TXEMPTY  7
`define SCI_IEN_TXDONE   6
`define SCI_IEN_RX       5
`define SCI_IEN_IDLE     4
`define SCI_CTRL2_TE     3
`define SCI_CTRL2_RE     2
`define SCI_BAUD_RST     8'h00
`define SCI_OVERSAMPLE   5'h10
`define SCI_POS_FIRST    5'h01
`define SCI_EDGE_HIGHS   2'h3
`endif

// ==== hdl/sci_pkg.sv ====
// Types shared by the receive status block and its helpers.
package sci_pkg;
   typedef struct packed {
      logic tx_empty_flag;
      logic tx_complete_flag;
      logic rx_full_flag;
      logic idle_flag;
      logic overrun_flag;
      logic noise_flag;
      logic framing_error_flag;
      logic parity_error_flag;
   } status_t;
   typedef struct packed {
      logic s3;
      logic s5;
      logic s7;
      logic s8;
      logic s9;
      logic s10;
   } rx_samples_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// ==== hdl/sci_bit_sampler.sv ====
// Sixteen-times oversampler that captures the sample points of one received bit.
`timescale 1ns/1ps
`include "sci_map.svh"
module sci_bit_sampler
   import sci_pkg::*;
(
   input  wire logic  ref_clk,  // Block clock.
   input  wire logic  rst,      // Asynchronous reset, high.
   input  wire logic  tick,     // Oversampling tick, already stopped in halt.
   input  wire logic  restart,  // Start edge seen on this tick.
   input  wire logic  rxd,      // Receive line level.
   output rx_samples_t samples, // Captured points of the last bit.
   output logic       bit_done  // Pulse after sample 16.
);
   logic [4:0]  pos;
   rx_samples_t cur;
   wire         at_end = (pos == `SCI_OVERSAMPLE);

   // Position counter; the edge tick itself is sample 1 of the start bit.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         pos <= 5'h00;
      else if (tick && restart)
         pos <= `SCI_POS_FIRST;
      else if (tick)
         pos <= at_end ? `SCI_POS_FIRST : 5'(pos + 5'h01);
   end

   // Capture the points the noise and majority decisions look at.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cur      <= '0;
         samples  <= '0;
         bit_done <= 1'b0;
      end
      else
      begin
         bit_done <= tick && !restart && at_end;
         if (tick && !restart)
         begin
            case (pos)
               5'h02:   cur.s3  <= rxd; // Count is one behind the sample taken.
               5'h04:   cur.s5  <= rxd;
               5'h06:   cur.s7  <= rxd;
               5'h07:   cur.s8  <= rxd;
               5'h08:   cur.s9  <= rxd;
               5'h09:   cur.s10 <= rxd;
               default: cur     <= cur;
            endcase
            if (at_end)
               samples <= cur;
         end
      end
   end
endmodule // sci_bit_sampler

// ==== hdl/sci_tx_shift.sv ====
// Transmit shifter: sends one frame per load, sixteen ticks per bit.
`timescale 1ns/1ps
`include "sci_map.svh"
module sci_tx_shift (
   input  wire logic       ref_clk, // Block clock.
   input  wire logic       rst,     // Asynchronous reset, high.
   input  wire logic       tick,    // Oversampling tick, stopped in halt.
   input  wire logic       load,    // Take a new word.
   input  wire logic       nine,    // Nine data bits.
   input  wire logic [8:0] word,    // Data bits, parity already placed.
   output logic            busy,    // Frame in progress.
   output logic            done,    // Pulse at end of stop bit.
   output logic            tx_line  // Serial output, idles high.
);
   logic [10:0] shreg;
   logic [3:0]  left;
   logic [3:0]  sub;
   wire  [10:0] frame = nine ? {1'b1, word, 1'b0} : {2'b11, word[7:0], 1'b0};

   // One shifter; the line is driven from the low bit of the register.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         shreg   <= 11'h7FF;
         left    <= 4'h0;
         sub     <= 4'h0;
         busy    <= 1'b0;
         done    <= 1'b0;
         tx_line <= 1'b1;
      end
      else
      begin
         done <= 1'b0;
         if (load && !busy)
         begin
            shreg   <= frame;
            left    <= nine ? 4'hB : 4'hA;
            sub     <= 4'h0;
            busy    <= 1'b1;
            tx_line <= 1'b0;
         end
         else if (busy && tick)
         begin
            sub <= 4'(sub + 4'h1);
            if (sub == 4'hF)
            begin
               shreg   <= {1'b1, shreg[10:1]};
               tx_line <= shreg[1];
               left    <= 4'(left - 4'h1);
               if (left == 4'h1)
               begin
                  busy    <= 1'b0;
                  done    <= 1'b1;
                  tx_line <= 1'b1;
               end
            end
         end
      end
   end
endmodule // sci_tx_shift

// ==== hdl/sci_status_core.sv ====
// Serial interface core: receive noise checks, status flags and interrupt request.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "sci_map.svh"
module sci_status_core
   import sci_pkg::*;
#(
   parameter int DIV_W = 8 // Width of the oversampling divider.
)
(
   input  wire logic       ref_clk,  // 40 MHz block clock.
   input  wire logic       rst,      // Asynchronous reset, high.
   input  wire logic [2:0] addr,     // Register address.
   input  wire logic [7:0] wdata,    // Write data.
   input  wire logic       wr,       // Write strobe.
   input  wire logic       rd,       // Read strobe.
   output logic      [7:0] rdata,    // Read data, cycle after rd.
   input  wire logic       rx_line,  // Serial receive line.
   output logic            tx_line,  // Serial transmit line.
   input  wire logic       halt,     // Device in Halt mode.
   input  wire logic       in_wait,  // Device in Wait mode.
   input  wire logic       irq_mask, // Global interrupt mask, high masks.
   output logic            irq_req,  // Shared serial interrupt request.
   output logic            wake_req  // Request to leave Wait mode.
);
   // Register state.
   status_t          st;
   logic [7:0]       rx_data;
   logic [7:0]       tx_hold;
   logic             r8;
   logic             t8;
   logic [7:0]       ctrl1;
   logic [7:0]       ctrl2;
   logic [DIV_W-1:0] baud_div;
   logic [DIV_W-1:0] bcnt;
   logic             status_seen;

   // Receive state.
   rx_state_t        rx_state;
   logic [1:0]       hi_run;
   logic             edge_noise;
   logic             noise_acc;
   logic             pend_noise;
   logic [8:0]       rx_shift;
   logic [3:0]       bit_cnt;
   logic [7:0]       idle_cnt;
   logic             idle_armed;

   // Helper outputs.
   rx_samples_t      smp;
   logic             bit_done;
   logic             tx_busy;
   logic             tx_done;

   // Control fields.
   wire m_nine = ctrl1[`SCI_CTRL1_M];
   wire pce    = ctrl1[`SCI_CTRL1_PCE];
   wire ps     = ctrl1[`SCI_CTRL1_PS];
   wire te     = ctrl2[`SCI_CTRL2_TE];
   wire re     = ctrl2[`SCI_CTRL2_RE];

   // Interrupt enables; noise and framing errors have none of their own.
   wire parity_irq_enable    = ctrl1[`SCI_IEN_PARITY];
   wire tx_empty_irq_enable  = ctrl2[`SCI_IEN_TXEMPTY];
   wire tx_done_irq_enable   = ctrl2[`SCI_IEN_TXDONE];
   wire rx_irq_enable        = ctrl2[`SCI_IEN_RX];
   wire line_idle_irq_enable = ctrl2[`SCI_IEN_IDLE];

   // Halt stops the divider, so nothing moves on the line while halted.
   wire tick = !halt && (bcnt == '0);
   wire run  = !halt;

   // Address decode.
   wire sel_status = (addr == `SCI_OFS_STATUS);
   wire sel_data   = (addr == `SCI_OFS_DATA);
   wire wr_data    = run && wr && sel_data;
   wire wr_ctrl1   = run && wr && (addr == `SCI_OFS_CTRL1);
   wire wr_ctrl2   = run && wr && (addr == `SCI_OFS_CTRL2);
   wire wr_baud    = run && wr && (addr == `SCI_OFS_BAUD);

   // Clear sequences only follow a status access.
   wire clr_rx     = run && rd && sel_data && status_seen;
   wire clr_tx     = run && wr && sel_data && status_seen;
   wire clr_parity = run && (rd || wr) && sel_data && status_seen;

   // Majority and disagreement of the three middle samples.
   wire maj     = (smp.s8 & smp.s9) | (smp.s8 & smp.s10) | (smp.s9 & smp.s10);
   wire mid_bad = !((smp.s8 == smp.s9) && (smp.s9 == smp.s10));
   wire mid_hi  = smp.s8 | smp.s9 | smp.s10;
   wire early_hi = smp.s3 | smp.s5 | smp.s7;

   // Word alignment and receive parity.
   wire [3:0] last_bit   = m_nine ? 4'h8 : 4'h7;
   wire [8:0] rx_word    = m_nine ? rx_shift : {1'b0, rx_shift[8:1]};
   wire       parity_bad = pce && ((^rx_word) ^ ps);

   // End of frame: stop bit is in the sampler outputs.
   wire frame_end  = run && re && bit_done && (rx_state == RX_STOP);
   wire stop_low   = !maj;

   // A word that finds rx full is an overrun only; its framing error is dropped.
   wire overrun    = frame_end && st.rx_full_flag;
   wire rx_xfer    = frame_end && !st.rx_full_flag;
   wire start_edge = run && re && tick && (rx_state == RX_IDLE) && !rx_line;
   wire false_start = run && bit_done && (rx_state == RX_START) && mid_hi;

   // Idle line is one whole frame time of high samples.
   wire [7:0] idle_len = m_nine ? 8'hB0 : 8'hA0;
   wire       idle_now = run && re && tick && rx_line && (rx_state == RX_IDLE) &&
                         idle_armed && (idle_cnt == 8'(idle_len - 8'h01));

   // Transmit word with optional parity in the top data bit.
   wire [8:0] tx_raw  = m_nine ? {t8, tx_hold} : {1'b0, tx_hold};
   wire       tx_par  = m_nine ? ((^tx_raw[7:0]) ^ ps) : ((^tx_raw[6:0]) ^ ps);
   wire [8:0] tx_word = !pce ? tx_raw :
                        m_nine ? {tx_par, tx_raw[7:0]} : {1'b0, tx_par, tx_raw[6:0]};
   wire       tx_load = run && te && !st.tx_empty_flag && !tx_busy;

   // Next status; a set in the clearing cycle wins.
   status_t next_st;
   assign next_st.tx_empty_flag      = tx_load || (st.tx_empty_flag && !clr_tx);
   assign next_st.tx_complete_flag   = (run && tx_done) ||
                                       (st.tx_complete_flag && !clr_tx);
   assign next_st.rx_full_flag       = rx_xfer || (st.rx_full_flag && !clr_rx);
   assign next_st.idle_flag          = idle_now || (st.idle_flag && !clr_rx);
   assign next_st.overrun_flag       = overrun || (st.overrun_flag && !clr_rx);
   assign next_st.noise_flag         = (rx_xfer && (noise_acc || mid_bad || pend_noise)) ||
                                       (st.noise_flag && !clr_rx);
   assign next_st.framing_error_flag = (rx_xfer && stop_low) ||
                                       (st.framing_error_flag && !clr_rx);
   assign next_st.parity_error_flag  = (rx_xfer && parity_bad) ||
                                       (st.parity_error_flag && !clr_parity);

   // Shared request; noise and framing have no enable and no request of their own.
   wire irq_event = (st.tx_empty_flag && tx_empty_irq_enable) ||
                    (st.tx_complete_flag && tx_done_irq_enable) ||
                    ((st.rx_full_flag || st.overrun_flag) && rx_irq_enable) ||
                    (st.idle_flag && line_idle_irq_enable) ||
                    (st.parity_error_flag && parity_irq_enable);

   // Read selection; status bits have no write path at all.
   wire [7:0] read_mux = sel_status ? st :
                         sel_data   ? rx_data :
                         (addr == `SCI_OFS_CTRL1) ? {r8, t8, ctrl1[5:0]} :
                         (addr == `SCI_OFS_CTRL2) ? ctrl2 :
                         (addr == `SCI_OFS_BAUD)  ? 8'(baud_div) : 8'h00;

   // Oversampling divider; divisor zero gives a tick every clock.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         bcnt <= '0;
      else if (run)
         bcnt <= (bcnt == '0) ? baud_div : DIV_W'(bcnt - 1'b1);
   end

   // Status register and the access tracker for clear sequences.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st          <= `SCI_STATUS_RST;
         status_seen <= 1'b0;
      end
      else if (run)
      begin
         st <= next_st;
         if ((rd || wr) && sel_status)
            status_seen <= 1'b1;
         else if ((rd || wr) && sel_data)
            status_seen <= 1'b0;
      end
   end

   // Software writable registers.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl1    <= 8'h00;
         ctrl2    <= 8'h00;
         t8       <= 1'b0;
         tx_hold  <= 8'h00;
         baud_div <= DIV_W'(`SCI_BAUD_RST);
      end
      else
      begin
         if (wr_ctrl1)
         begin
            ctrl1 <= {2'b00, wdata[5:0]};
            t8    <= wdata[6];
         end
         if (wr_ctrl2)
            ctrl2 <= {wdata[7:2], 2'b00};
         if (wr_baud)
            baud_div <= wdata[DIV_W-1:0];
         if (wr_data)
            tx_hold <= wdata;
      end
   end

   // Count of consecutive high samples ahead of a start edge.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         hi_run <= 2'h0;
      else if (tick)
         hi_run <= !rx_line ? 2'h0 :
                   (hi_run == `SCI_EDGE_HIGHS) ? hi_run : 2'(hi_run + 2'h1);
   end

   // Receive sequencer over start, data and stop bits.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_state   <= RX_IDLE;
         edge_noise <= 1'b0;
         noise_acc  <= 1'b0;
         pend_noise <= 1'b0;
         rx_shift   <= 9'h000;
         bit_cnt    <= 4'h0;
      end
      else if (run && re)
      begin
         if (rx_xfer)
            pend_noise <= 1'b0;
         case (rx_state)
            RX_IDLE:
               if (start_edge)
               begin
                  rx_state   <= RX_START;
                  edge_noise <= (hi_run != `SCI_EDGE_HIGHS);
               end
            RX_START:
               if (false_start)
               begin
                  // A rejected start is remembered and shown with the next good word.
                  rx_state   <= RX_IDLE;
                  pend_noise <= 1'b1;
               end
               else if (bit_done)
               begin
                  rx_state  <= RX_DATA;
                  noise_acc <= edge_noise || early_hi;
                  bit_cnt   <= 4'h0;
               end
            RX_DATA:
               if (bit_done)
               begin
                  rx_shift  <= {maj, rx_shift[8:1]};
                  noise_acc <= noise_acc || mid_bad;
                  bit_cnt   <= 4'(bit_cnt + 4'h1);
                  if (bit_cnt == last_bit)
                     rx_state <= RX_STOP;
               end
            RX_STOP:
               if (bit_done)
                  rx_state <= RX_IDLE;
            default:
               rx_state <= RX_IDLE;
         endcase
      end
      else if (run)
         rx_state <= RX_IDLE;
   end

   // Received word transfer; on overrun the held word is kept.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_data <= 8'h00;
         r8      <= 1'b0;
      end
      else if (rx_xfer)
      begin
         rx_data <= rx_word[7:0];
         r8      <= rx_word[8];
      end
   end

   // Idle timing; one idle report per received word.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         idle_cnt   <= 8'h00;
         idle_armed <= 1'b1;
      end
      else if (run)
      begin
         if (tick)
            idle_cnt <= (!rx_line || rx_state != RX_IDLE || idle_now) ? 8'h00 :
                        (idle_cnt == 8'hFF) ? idle_cnt : 8'(idle_cnt + 8'h01);
         if (rx_xfer)
            idle_armed <= 1'b1;
         else if (idle_now)
            idle_armed <= 1'b0;
      end
   end

   // Registered outputs: read data, interrupt and wake requests.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rdata    <= 8'h00;
         irq_req  <= 1'b0;
         wake_req <= 1'b0;
      end
      else
      begin
         rdata    <= rd ? read_mux : 8'h00;
         irq_req  <= irq_event && !irq_mask;
         wake_req <= irq_event && !irq_mask && in_wait && !halt;
      end
   end

   // Oversampler for the receive line.
   sci_bit_sampler u_sampler (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .tick     (tick && re),
      .restart  (start_edge),
      .rxd      (rx_line),
      .samples  (smp),
      .bit_done (bit_done)
   );

   // Transmit shifter.
   sci_tx_shift u_tx (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (tick),
      .load    (tx_load),
      .nine    (m_nine),
      .word    (tx_word),
      .busy    (tx_busy),
      .done    (tx_done),
      .tx_line (tx_line)
   );
endmodule // sci_status_core

// ==== sim/sci_status_checker.sv ====
// Port-level assertions for the serial status core.
`timescale 1ns/1ps
module sci_status_checker (
   input wire logic       ref_clk,  // Block clock.
   input wire logic       rst,      // Reset, high.
   input wire logic [2:0] addr,     // Register address.
   input wire logic       rd,       // Read strobe.
   input wire logic [7:0] rdata,    // Read data.
   input wire logic       tx_line,  // Serial output.
   input wire logic       halt,     // Halt level.
   input wire logic       in_wait,  // Wait level.
   input wire logic       irq_mask, // Global mask.
   input wire logic       irq_req,  // Shared request.
   input wire logic       wake_req  // Wake request.
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Status read then data read; the bench leaves one idle cycle between strobes.
   sequence stat_rd;
      rd && addr == 3'h0;
   endsequence
   sequence clr_seq;
      stat_rd ##2 (rd && addr == 3'h1);
   endsequence

   reset_value_a: assert property
      ($past(rst) && rd && addr == 3'h0 |=> rdata == 8'hC0) else $error("Bad reset status.");
   rdata_quiet_a: assert property
      (!rd |=> rdata == 8'h00) else $error("Read data outside read cycle.");
   flags_clear_a: assert property
      (clr_seq ##2 stat_rd |=> rdata[3:1] == 3'h0) else $error("Clear sequence left flags.");
   mask_gate_a: assert property
      (irq_mask |=> !irq_req) else $error("Request while masked.");
   wait_only_a: assert property
      (!in_wait |=> !wake_req) else $error("Wake outside wait.");
   halt_nowake_a: assert property
      (halt |=> !wake_req) else $error("Wake during halt.");
   halt_freeze_a: assert property
      (halt [*2] |-> $stable(tx_line)) else $error("Line moved in halt.");
   start_len_a: assert property
      ($fell(tx_line) |-> (!tx_line) [*8] ##1 (!tx_line) [*7]) else $error("Short start bit.");
endmodule // sci_status_checker

bind sci_status_core sci_status_checker u_chk (.ref_clk(ref_clk), .rst(rst), .addr(addr),
   .rd(rd), .rdata(rdata), .tx_line(tx_line), .halt(halt), .in_wait(in_wait),
   .irq_mask(irq_mask), .irq_req(irq_req), .wake_req(wake_req));

// ==== sim/sci_link_model.sv ====
// Remote transmitter model: one frame per request, sixteen clocks per bit.
`timescale 1ns/1ps
module sci_link_model (
   input  wire logic       ref_clk,  // Block clock, one tick each.
   input  wire logic       send,     // Start one frame.
   input  wire logic [7:0] data,     // Byte, sent LSB first.
   input  wire logic       glitch,   // Flip one middle sample of data bit 0.
   input  wire logic       bad_stop, // Send a low stop bit.
   output logic            line,     // Serial line, idles high.
   output logic            busy      // Frame in progress.
);
   logic [7:0] cnt;
   logic [9:0] frame;
   logic       flip;

   // Frame counter; a request while busy is dropped, so the bench must pace frames.
   always @(posedge ref_clk)
   begin
      if (!busy && send)
      begin
         frame <= {~bad_stop, data, 1'b0};
         flip  <= glitch;
         cnt   <= 8'h00;
         busy  <= 1'b1;
      end
      else if (busy)
      begin
         cnt  <= cnt + 8'h01;
         busy <= (cnt != 8'h9F);
      end
   end

   // Bit index is cnt/16; offset 8 inside bit 1 is the ninth sample.
   assign line = busy ? frame[cnt[7:4]] ^ (flip && cnt == 8'h18) : 1'b1;

   initial
   begin
      busy = 1'b0;
      cnt  = 8'h00;
   end
endmodule // sci_link_model

// ==== sim/tb_sci_rx_noise_status_irq.sv ====
// Self-checking bench for the serial status core.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_sci_rx_noise_status_irq;
   logic       ref_clk = 1'b0;
   logic       rst     = 1'b1;
   logic [2:0] addr    = 3'h0;
   logic [7:0] wdata   = 8'h00;
   logic       wr      = 1'b0;
   logic       rd      = 1'b0;
   logic       halt    = 1'b0;
   logic       in_wait = 1'b0;
   logic       irq_mask = 1'b1;
   logic       m_send  = 1'b0;
   logic [7:0] m_data  = 8'h00;
   logic       m_glitch = 1'b0;
   logic       m_bad   = 1'b0;
   logic [7:0] rdata, q, b, got;
   logic       rx_line, tx_line, irq_req, wake_req, m_busy, n;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         k;

   // Expected receive flags: rx full, plus noise when a middle sample was disturbed.
   function automatic logic [7:0] rx_flags(input logic noisy);
      return {2'b00, 1'b1, 2'b00, noisy, 2'b00};
   endfunction

   always #12.5 ref_clk = ~ref_clk;

   sci_status_core dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .rx_line(rx_line), .tx_line(tx_line), .halt(halt),
      .in_wait(in_wait), .irq_mask(irq_mask), .irq_req(irq_req), .wake_req(wake_req));
   sci_link_model peer (.ref_clk(ref_clk), .send(m_send), .data(m_data), .glitch(m_glitch),
      .bad_stop(m_bad), .line(rx_line), .busy(m_busy));

   // One bus access; read data are taken in the single cycle they stand.
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr <= w; rd <= !w; addr <= a; wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0; rd <= 1'b0;
      #1 q = rdata;
   endtask

   // A frame takes ten bits of sixteen clocks, so a fixed wait covers it.
   task automatic frame(input logic [7:0] d, input logic g, input logic s);
      @(posedge ref_clk);
      m_data <= d; m_glitch <= g; m_bad <= s; m_send <= 1'b1;
      @(posedge ref_clk);
      m_send <= 1'b0;
      repeat (175) @(posedge ref_clk);
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      k = $urandom(32'h9cca_c8e2);
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0; rd <= 1'b1; addr <= 3'h0;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 `CHK("reset status", 8'hC0, rdata)
      acc(1'b1, 3'h0, 8'h00); acc(1'b0, 3'h0, 8'h00);
      `CHK("status ro", 8'hC0, q)
      acc(1'b0, 3'h7, 8'h00);
      `CHK("unmapped", 8'h00, q)
      acc(1'b1, 3'h3, 8'h2C);
      @(posedge ref_clk);
      irq_mask <= 1'b0;
      acc(1'b0, 3'h1, 8'h00);
      // Random bytes, alternately with a noisy middle sample.
      for (int i = 0; i < 4; i++)
      begin
         b = $urandom;
         n = i[0];
         frame(b, n, 1'b0);
         `CHK("rx irq", 1'b1, irq_req)
         acc(1'b0, 3'h1, 8'h00);
         `CHK("rx data", b, q)
         acc(1'b0, 3'h0, 8'h00);
         `CHK("rx status", rx_flags(n), q & 8'h2F)
         acc(1'b0, 3'h1, 8'h00); acc(1'b0, 3'h0, 8'h00);
         `CHK("cleared", 8'h00, q & 8'h2F)
         `CHK("irq off", 1'b0, irq_req)
         acc(1'b0, 3'h1, 8'h00);
      end
      // Second word, with a bad stop bit, arrives while the first is unread.
      b = $urandom;
      frame(b, 1'b0, 1'b0); frame(~b, 1'b0, 1'b1);
      acc(1'b0, 3'h0, 8'h00);
      `CHK("overrun status", 8'h28, q & 8'h2F)
      acc(1'b0, 3'h1, 8'h00);
      `CHK("overrun data", b, q)
      frame(b, 1'b0, 1'b1);
      acc(1'b0, 3'h0, 8'h00);
      `CHK("framing", 8'h22, q & 8'h2F)
      acc(1'b0, 3'h1, 8'h00);
      // Even parity over eight bits; a single set bit is a mismatch.
      acc(1'b1, 3'h2, 8'h05);
      frame(8'h01, 1'b0, 1'b0);
      acc(1'b0, 3'h0, 8'h00);
      `CHK("parity", 8'h21, q & 8'h2F)
      acc(1'b0, 3'h1, 8'h00);
      `CHK("parity data", 8'h01, q)
      acc(1'b0, 3'h0, 8'h00);
      `CHK("parity clear", 8'h00, q & 8'h2F)
      acc(1'b1, 3'h2, 8'h00);
      // Pending word: wake in wait, none in halt, no request while masked.
      frame(b, 1'b0, 1'b0);
      in_wait <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("wake", 1'b1, wake_req)
      halt <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("halt wake", 1'b0, wake_req)
      halt <= 1'b0; in_wait <= 1'b0; irq_mask <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("masked", 1'b0, irq_req)
      irq_mask <= 1'b0;
      // Transmit a random byte and decode it at mid-bit.
      acc(1'b0, 3'h0, 8'h00);
      b = $urandom;
      acc(1'b1, 3'h1, b);
      k = 0;
      while (tx_line !== 1'b0 && k < 50)
      begin
         @(posedge ref_clk);
         k++;
      end
      if (k == 50)
      begin
         error_cnt++;
         final_report();
      end
      repeat (8) @(posedge ref_clk);
      for (int j = 0; j < 8; j++)
      begin
         repeat (16) @(posedge ref_clk);
         got[j] = tx_line;
      end
      `CHK("tx byte", b, got)
      repeat (30) @(posedge ref_clk);
      acc(1'b0, 3'h0, 8'h00);
      `CHK("tx flags", 8'hC0, q & 8'hC0)
      final_report();
   end
endmodule // tb_sci_rx_noise_status_irq
